// ===== rtl/isft_fifo.sv
// Purpose: Pixel word buffer with registered output
// Assumes: DEPTH is a power of two
// Notes:   in_ready low means full
`timescale 1ns/10ps
module isft_fifo #(
   parameter int WIDTH = 36,
   parameter int DEPTH = 16
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   output logic                  out_valid,
   output logic      [WIDTH-1:0] out_data,
   input  wire logic             out_ready
);
   localparam int PW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0]               wr;
      logic [PW-1:0]               rd;
      logic [PW:0]                 count;
      logic                        ov;
      logic [WIDTH-1:0]            od;
   } isft_fifo_state_t;

   isft_fifo_state_t st_reg;
   isft_fifo_state_t st_next;
   logic             push;
   logic             pop;

   assign in_ready  = (st_reg.count != (PW+1)'(DEPTH));
   assign out_valid = st_reg.ov;
   assign out_data  = st_reg.od;

   always_comb begin
      st_next = st_reg;
      push    = in_valid && in_ready;
      pop     = (!st_reg.ov || out_ready) && (st_reg.count != '0);
      if (!st_reg.ov || out_ready) begin
         st_next.ov = pop;
      end
      if (pop) begin
         st_next.od = st_reg.mem[st_reg.rd];
         st_next.rd = st_reg.rd + 1'b1;
      end
      if (push) begin
         st_next.mem[st_reg.wr] = in_data;
         st_next.wr             = st_reg.wr + 1'b1;
      end
      if (push && !pop) begin
         st_next.count = st_reg.count + 1'b1;
      end else if (pop && !push) begin
         st_next.count = st_reg.count - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
endmodule : isft_fifo

// ===== rtl/isft_pkg.sv
// Function
// R1: Controller ends integration exactly where that frame's readout starts; here it ends at sample activation, readout waits for boost high.
// R2: Integration runs from reset falling to sample activating.
// R3: Precharge drops no earlier than memory boost falls.
// R4: Sample active interval overlaps precharge during memory transfer.
// R5: Memory boost returns high over 200 ns after sample activates.
// R6: Reset rises no earlier than memory boost returns high.
// R7: Boost low 5-8.2 us, precharge 3-6 us, sample 5-8 us.
// R8: Precharge-to-sample over 2 us; integration kept above its minimum.
// R9: Boost envelops precharge and sample; readout only after boost high.
// R10: Optional second-slope reset pulse of at least 2 us during integration.
// R11: Row sync loads first row as row start times two.
// R12: Each row step rising edge selects the next line.
// R13: Row sync has priority and reinitialises rows immediately.
// R14: Row sync held over 20 ns containing a row step rise.
// R15: Controller waits row overhead time before reading 2048 pixels.
// R16: Two pixels per pair clock period, per phase or per output.
// R17: First column is column start times two, loaded on column sync.
// R18: Pixels presented after column sync plus one pair clock rise.
// R19: Controller sets window size by row step and row sync timing.
// R20: Controller keeps its ADC sampling point adjustable, 5 to 15 ns.
// R21: Standard timing: 20 ns deselect/preset, track/hold low, 180 ns wait.
// R22: Backup timing: 100-200 ns track/hold pulse sets row overhead.
// R23: Averaging pulse over 20 ns after track/hold falls, before readout.
// R24: Main reset dominates second-slope reset when both are asserted.
// R25: Controller derives pulse widths from counters, rounding minimums up.
// Purpose: Shared constants for the sensor frame timing block
// Assumes: 250 MHz system clock
// Notes:   Pin indices address the synchroniser vector
package isft_pkg;
   localparam int          CLK_MHZ     = 250;
   localparam int          IN_N        = 8;
   localparam int          PIN_ROW_SYNC = 0;
   localparam int          PIN_ROW_STEP = 1;
   localparam int          PIN_COL_SYNC = 2;
   localparam int          PIN_PAIR_CLK = 3;
   localparam int          PIN_RESET    = 4;
   localparam int          PIN_SSRESET  = 5;
   localparam int          PIN_BOOST    = 6;
   localparam int          PIN_SAMPLE_N = 7;
   localparam int          START_W     = 10;
   localparam int          ADDR_W      = 12;
   localparam int          INT_W       = 28;
   localparam int          WORD_W      = 3 * ADDR_W;
   localparam int          FIFO_DEPTH  = 16;
   localparam logic [1:0]  LVL_NONE    = 2'h0;
   localparam logic [1:0]  LVL_SLOPE2  = 2'h1;
   localparam logic [1:0]  LVL_MAIN    = 2'h2;
   localparam logic [IN_N-1:0] SYNC_RST = 8'h80;
endpackage : isft_pkg

// ===== rtl/isft_top.sv
// Purpose: Sensor-side row/column addressing and pixel array control
// Assumes: Control pins asynchronous to clk; start values static
// Notes:   Pixel words are {row, second pixel, first pixel}
`timescale 1ns/10ps
module isft_top
   import isft_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               rst,
   input  wire logic               row_sync,
   input  wire logic               row_step,
   input  wire logic               col_sync,
   input  wire logic               pair_clk,
   input  wire logic               reset_ctl,
   input  wire logic               second_slope_reset,
   input  wire logic               memory_boost_ctl,
   input  wire logic               sample_n,
   input  wire logic [START_W-1:0] row_start,
   input  wire logic [START_W-1:0] col_start,
   input  wire logic               dual_output,
   output logic      [ADDR_W-1:0]  row_addr,
   output logic                    col_active,
   output logic      [1:0]         reset_level,
   output logic                    frame_overhead,
   output logic                    integrating,
   output logic      [INT_W-1:0]   integ_cycles,
   output logic                    overrun,
   output logic                    pix_valid,
   output logic      [WORD_W-1:0]  pix_word,
   input  wire logic               pix_ready
);
   typedef struct packed {
      logic [IN_N-1:0]   s1;
      logic [IN_N-1:0]   s2;
      logic [IN_N-1:0]   s3;
      logic [ADDR_W-1:0] row;
      logic [ADDR_W-1:0] col;
      logic              col_act;
      logic [INT_W-1:0]  int_cnt;
      logic [INT_W-1:0]  int_last;
      logic              int_run;
      logic [1:0]        lvl;
      logic              ovh;
      logic              push;
      logic [WORD_W-1:0] word;
      logic              ovr;
   } isft_state_t;

   isft_state_t st_reg;
   isft_state_t st_next;
   logic        fifo_ready;

   function automatic logic [ADDR_W-1:0] start_x2(
      input logic [START_W-1:0] s
   );
      start_x2 = ADDR_W'({s, 1'b0});
   endfunction : start_x2

   function automatic logic [WORD_W-1:0] mk_word(
      input logic [ADDR_W-1:0] r,
      input logic [ADDR_W-1:0] b,
      input logic [ADDR_W-1:0] a
   );
      mk_word = {r, b, a};
   endfunction : mk_word

   logic pin_rise [IN_N];
   logic pin_fall [IN_N];

   genvar gi;
   generate
      for (gi = 0; gi < IN_N; gi++) begin : g_edge
         assign pin_rise[gi] = st_reg.s2[gi] && !st_reg.s3[gi];
         assign pin_fall[gi] = !st_reg.s2[gi] && st_reg.s3[gi];
      end
   endgenerate

   always_comb begin
      logic [ADDR_W-1:0] c1;
      st_next    = st_reg;
      c1         = st_reg.col + 1'b1;
      st_next.s1 = {sample_n, memory_boost_ctl, second_slope_reset,
                    reset_ctl, pair_clk, col_sync, row_step, row_sync};
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      st_next.push = 1'b0;

      // Reset level onto the pixels
      if (st_reg.s2[PIN_RESET]) begin
         st_next.lvl = LVL_MAIN; // R24
      end else if (st_reg.s2[PIN_SSRESET]) begin
         st_next.lvl = LVL_SLOPE2; // R10
      end else begin
         st_next.lvl = LVL_NONE;
      end

      // Integration from reset fall to sample activation
      if (pin_fall[PIN_RESET]) begin
         st_next.int_run = 1'b1; // R2
         st_next.int_cnt = INT_W'(1);
      end else if (st_reg.int_run) begin
         if (pin_fall[PIN_SAMPLE_N]) begin
            st_next.int_run  = 1'b0; // R2
            st_next.int_last = st_reg.int_cnt;
         end else if (st_reg.int_cnt != '1) begin
            st_next.int_cnt = st_reg.int_cnt + 1'b1;
         end
      end

      // Readout gated while boost envelope is low
      st_next.ovh = !st_reg.s2[PIN_BOOST]; // R9

      // Row addressing, sync dominant
      if (st_reg.s2[PIN_ROW_SYNC]) begin
         st_next.row     = start_x2(row_start); // R11 R13
         st_next.col_act = 1'b0;
      end else if (pin_rise[PIN_ROW_STEP]) begin
         st_next.row     = st_reg.row + 1'b1; // R12
         st_next.col_act = 1'b0;
      end

      // Column addressing
      if (st_reg.s2[PIN_COL_SYNC]) begin
         st_next.col       = start_x2(col_start); // R17
         st_next.col_act   = 1'b0;
      end
      if (st_reg.s2[PIN_COL_SYNC] && pin_rise[PIN_PAIR_CLK]
          && !st_reg.ovh && !st_reg.s2[PIN_ROW_SYNC]) begin
         st_next.col_act   = 1'b1; // R18
         st_next.col       = start_x2(col_start);
         st_next.push      = 1'b1;
         st_next.word      = dual_output
            ? mk_word(st_reg.row, start_x2(col_start) + 1'b1,
                      start_x2(col_start))
            : mk_word(st_reg.row, start_x2(col_start),
                      start_x2(col_start));
      end else if (st_reg.col_act && !st_reg.ovh
                   && !st_reg.s2[PIN_COL_SYNC]
                   && !st_reg.s2[PIN_ROW_SYNC]
                   && !pin_rise[PIN_ROW_STEP]) begin
         if (pin_rise[PIN_PAIR_CLK]) begin
            st_next.col  = st_reg.col + ADDR_W'(2); // R16
            st_next.push = 1'b1;
            st_next.word = dual_output
               ? mk_word(st_reg.row, st_reg.col + ADDR_W'(3),
                         st_reg.col + ADDR_W'(2))
               : mk_word(st_reg.row, st_reg.col + ADDR_W'(2),
                         st_reg.col + ADDR_W'(2));
         end else if (pin_fall[PIN_PAIR_CLK] && !dual_output) begin
            st_next.push = 1'b1; // R16
            st_next.word = mk_word(st_reg.row, c1, c1);
         end
      end

      if (st_reg.push && !fifo_ready) begin
         st_next.ovr = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg    <= '0;
         st_reg.s1 <= SYNC_RST;
         st_reg.s2 <= SYNC_RST;
         st_reg.s3 <= SYNC_RST;
         st_reg.ovh <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   isft_fifo #(
      .WIDTH (WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (st_reg.push),
      .in_data   (st_reg.word),
      .in_ready  (fifo_ready),
      .out_valid (pix_valid),
      .out_data  (pix_word),
      .out_ready (pix_ready)
   );

   assign row_addr       = st_reg.row;
   assign col_active     = st_reg.col_act;
   assign reset_level    = st_reg.lvl;
   assign frame_overhead = st_reg.ovh;
   assign integrating    = st_reg.int_run;
   assign integ_cycles   = st_reg.int_last;
   assign overrun        = st_reg.ovr;
endmodule : isft_top

// ===== tb/isft_assertions.sv
// Purpose: Port checks for the frame timing top
// Assumes: Pin effects settle within six clocks
// Notes:   Bound to every isft_top
`timescale 1ns/10ps
module isft_assertions
   import isft_pkg::*;
(
   input wire logic               clk,
   input wire logic               rst,
   input wire logic               row_sync,
   input wire logic               row_step,
   input wire logic               reset_ctl,
   input wire logic               second_slope_reset,
   input wire logic               memory_boost_ctl,
   input wire logic               sample_n,
   input wire logic [START_W-1:0] row_start,
   input wire logic [ADDR_W-1:0]  row_addr,
   input wire logic [1:0]         reset_level,
   input wire logic               frame_overhead,
   input wire logic               integrating,
   input wire logic               pix_valid,
   input wire logic [WORD_W-1:0]  pix_word,
   input wire logic               pix_ready
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   chk_row_load: assert property (row_sync[*6] |->
      row_addr == {1'b0, row_start, 1'b0}) else $error("row load");
   chk_row_next: assert property (!row_sync[*6] ##0 $rose(row_step)
      |-> ##[1:5] row_addr == $past(row_addr) + 12'h1)
      else $error("row step");
   chk_main_wins: assert property (reset_ctl[*6]
      |-> reset_level == LVL_MAIN) else $error("main reset level");
   chk_slope_only: assert property ((second_slope_reset && !reset_ctl)[*6]
      |-> reset_level == LVL_SLOPE2) else $error("second slope level");
   chk_boost_low: assert property (!memory_boost_ctl[*6]
      |-> frame_overhead) else $error("overhead low");
   chk_boost_high: assert property (memory_boost_ctl[*6]
      |-> !frame_overhead) else $error("overhead high");
   chk_sample_stop: assert property (!sample_n[*6]
      |-> !integrating) else $error("integration stop");
   chk_word_hold: assert property (pix_valid && !pix_ready
      |=> pix_valid && $stable(pix_word)) else $error("word hold");
endmodule : isft_assertions
bind isft_top isft_assertions i_isft_assertions (.*);

// ===== tb/isft_ctrl_model.sv
// Purpose: Controller model making the pixel-pair clock
// Assumes: 80 ns period from the 4 ns clock
// Notes:   Clock finishes its high phase, then stands low while run is low
`timescale 1ns/10ps
module isft_ctrl_model (
   input  wire logic clk,
   input  wire logic run,
   output logic      pair_clk
);
   int cnt = 0;
   initial pair_clk = 1'b0;
   always @(posedge clk) begin
      if (!run && !pair_clk) begin
         cnt <= 0;
      end else if (cnt == 9) begin
         cnt <= 0;
         pair_clk <= !pair_clk;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule : isft_ctrl_model

// ===== tb/isft_top_test.sv
// Purpose: Self-checking bench for the frame timing top
// Assumes: Pins change on clk rising edges
// Notes:   Expected pixel words kept in a queue
`timescale 1ns/10ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin bad_count++; \
   $display("ERROR %s expected %0h seen %0h", n, e, a); end end
module isft_top_test;
   import isft_pkg::*;
   logic clk = 0, rst = 1, row_sync = 0, row_step = 0, col_sync = 0;
   logic reset_ctl = 0, second_slope_reset = 0, memory_boost_ctl = 1;
   logic sample_n = 1, dual_output = 0, pix_ready = 0, run = 0, hold = 0;
   logic [START_W-1:0] row_start = '0, col_start = '0;
   logic [ADDR_W-1:0]  row_addr, exp_row;
   logic [1:0]         reset_level, lv;
   logic               col_active, frame_overhead, integrating, overrun;
   logic               pix_valid, pair_clk;
   logic [INT_W-1:0]   integ_cycles;
   logic [WORD_W-1:0]  pix_word, ew, q[$];
   logic [31:0]        seed = 32'h7, rr;
   int                 bad_count = 0, checks = 0, popped = 0, n;
   isft_top i_isft_top (.*);
   isft_ctrl_model i_isft_ctrl_model (.clk(clk), .run(run),
      .pair_clk(pair_clk));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic tick(int k);
      repeat (k) @(posedge clk);
   endtask : tick
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : stop_test
   initial forever #2 clk = ~clk;
   initial begin
      #40000;
      bad_count++;
      stop_test();
   end
   always @(posedge clk) begin
      rr = rnd();
      pix_ready <= !hold && rr[0];
      if (pix_valid && pix_ready) begin
         popped++;
         ew = (q.size() > 0) ? q.pop_front() : '1;
         `CHK("pix_word", ew, pix_word)
      end
   end
   task automatic row_frame(int steps);
      logic [31:0] r;
      r = rnd();
      @(posedge clk);
      row_start <= r[START_W-1:0];
      row_sync <= 1;
      tick(3);
      row_step <= 1;
      tick(3);
      row_step <= 0;
      tick(3);
      row_sync <= 0;
      tick(6);
      #1;
      exp_row = {1'b0, row_start, 1'b0};
      `CHK("row_first", exp_row, row_addr)
      repeat (steps) begin
         @(posedge clk);
         row_step <= 1;
         tick(4);
         row_step <= 0;
         tick(4);
         #1;
         exp_row++;
         `CHK("row_next", exp_row, row_addr)
      end
      $display("row frame test done");
   endtask : row_frame
   task automatic readout(int per, logic dual, logic live);
      logic [31:0] r;
      logic [ADDR_W-1:0] c;
      r = rnd();
      c = {1'b0, r[START_W-1:0], 1'b0};
      for (int k = 0; k < per && live; k++) begin
         q.push_back(dual ? {exp_row, c + 12'h1, c} : {exp_row, c, c});
         if (!dual) q.push_back({exp_row, c + 12'h1, c + 12'h1});
         c += 12'h2;
      end
      tick(50);
      @(posedge clk);
      col_start <= r[START_W-1:0];
      dual_output <= dual;
      col_sync <= 1;
      run <= 1;
      @(posedge pair_clk);
      tick(1);
      col_sync <= 0;
      repeat (per) @(negedge pair_clk);
      run <= 0;
      #1;
      `CHK("col_active", live, col_active)
   endtask : readout
   task automatic drained(string what);
      tick(60);
      #1;
      `CHK("left", 32'h0, 32'(q.size()))
      `CHK("pix_valid", 1'b0, pix_valid)
      $display("%s test done", what);
   endtask : drained
   initial begin
      tick(5);
      rst <= 0;
      tick(2);
      #1;
      `CHK("row_addr", 12'h0, row_addr)
      `CHK("reset_level", LVL_NONE, reset_level)
      row_frame(3);
      row_frame(2);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         reset_ctl <= i[1];
         second_slope_reset <= i[0];
         tick(6);
         #1;
         lv = i[1] ? LVL_MAIN : (i[0] ? LVL_SLOPE2 : LVL_NONE);
         `CHK("reset_level", lv, reset_level)
      end
      n = 1100 + rnd() % 32;
      @(posedge clk);
      second_slope_reset <= 0;
      reset_ctl <= 0;
      tick(100);
      second_slope_reset <= 1;
      tick(500);
      #1;
      `CHK("reset_level", LVL_SLOPE2, reset_level)
      tick(4);
      second_slope_reset <= 0;
      tick(n - 608);
      memory_boost_ctl <= 0;
      tick(4);
      sample_n <= 0;
      #1;
      `CHK("integrating", 1'b1, integrating)
      tick(8);
      #1;
      `CHK("integ_cycles", INT_W'(n), integ_cycles)
      `CHK("integrating", 1'b0, integrating)
      `CHK("frame_overhead", 1'b1, frame_overhead)
      $display("integration test done");
      readout(2, 0, 0);
      drained("refused readout");
      tick(1160);
      sample_n <= 1;
      tick(52);
      memory_boost_ctl <= 1;
      reset_ctl <= 1;
      tick(8);
      #1;
      `CHK("frame_overhead", 1'b0, frame_overhead)
      readout(4, 0, 1);
      drained("single output");
      readout(4, 1, 1);
      drained("dual output");
      @(posedge clk);
      hold <= 1;
      readout(10, 0, 1);
      tick(4);
      #1;
      `CHK("overrun", 1'b1, overrun)
      n = popped;
      @(posedge clk);
      hold <= 0;
      tick(100);
      #1;
      `CHK("fifo_depth", 1'b1, popped - n >= FIFO_DEPTH)
      q.delete();
      drained("buffer fill");
      stop_test();
   end
endmodule : isft_top_test
